// File: include/uart_chan_pkg.sv
// Register map, field positions, reset values and bit timing for one serial channel.
package uart_chan_pkg;
    // Register addresses on the three-bit address bus.
    localparam logic [2:0] ADDR_DATA  = 3'h0;
    localparam logic [2:0] ADDR_MASK  = 3'h1;
    localparam logic [2:0] ADDR_CAUSE = 3'h2;
    localparam logic [2:0] ADDR_FMT   = 3'h3;
    localparam logic [2:0] ADDR_MODEM = 3'h4;
    localparam logic [2:0] ADDR_LINE  = 3'h5;

    // Field positions.
    localparam int MASK_RX    = 0;
    localparam int MASK_TX    = 1;
    localparam int MASK_LINE  = 2;
    localparam int MASK_MODEM = 3;
    localparam int FMT_STOP   = 2;
    localparam int FMT_PAR_EN = 3;
    localparam int FMT_EVEN   = 4;
    localparam int FMT_FORCE  = 5;
    localparam int FMT_BREAK  = 6;
    localparam int MDM_DTR    = 0;
    localparam int MDM_RTS    = 1;
    localparam int MDM_OUT1   = 2;
    localparam int MDM_OUT2   = 3;
    localparam int MDM_LOOP   = 4;

    // Writable bits and reset value of the control registers.
    localparam logic [7:0] MASK_WMASK  = 8'h0F;
    localparam logic [7:0] FMT_WMASK   = 8'h7F;
    localparam logic [7:0] MODEM_WMASK = 8'h1F;
    localparam logic [7:0] REG_RESET   = 8'h00;

    // Interrupt cause codes, highest priority first.
    localparam logic [3:0] CAUSE_LINE  = 4'h6;
    localparam logic [3:0] CAUSE_RX    = 4'h4;
    localparam logic [3:0] CAUSE_TX    = 4'h2;
    localparam logic [3:0] CAUSE_MODEM = 4'h0;
    localparam logic [3:0] CAUSE_NONE  = 4'h1;

    // Bit timing in 16x baud ticks.
    localparam logic [3:0] START_CHECK = 4'h7;
    localparam logic [3:0] BIT_LAST    = 4'hF;
    localparam logic [4:0] STOP_ONE    = 5'h0F;
    localparam logic [4:0] STOP_HALF3  = 5'h17;
    localparam logic [4:0] STOP_TWO    = 5'h1F;
    localparam logic [1:0] LEN_FIVE    = 2'h0;

    // Two-entry transmit buffer.
    localparam logic [1:0] BUF_FULL  = 2'h2;
    localparam logic [1:0] BUF_EMPTY = 2'h0;

    // Mask keeping only the bits of the selected character length.
    function automatic logic [7:0] len_mask(input logic [1:0] len);
        len_mask = 8'hFF >> (2'h3 - len);
    endfunction

    // Parity bit for a character under the current line format.
    function automatic logic parity_bit(input logic [7:0] data, input logic [7:0] fmt);
        if (fmt[FMT_FORCE])
            parity_bit = ~fmt[FMT_EVEN];
        else
            parity_bit = ~fmt[FMT_EVEN] ^ (^(data & len_mask(fmt[1:0])));
    endfunction
endpackage

// File: include/byte_stream_if.sv
// Byte stream carrier with valid and ready between the channel and its buffer.
`timescale 1ns/100ps
interface byte_stream_if;
    logic [7:0] data;
    logic       valid;
    logic       ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface

// File: src/byte_pair_buffer.sv
// Two-entry byte buffer with valid and ready on both sides.
`timescale 1ns/100ps
module byte_pair_buffer
    import uart_chan_pkg::*;
(
    input  wire logic   i_clk,
    input  wire logic   i_sys_rst,
    byte_stream_if.snk  in_s,
    byte_stream_if.src  out_s
);
    logic [7:0] slot [2];
    logic       wr_ptr;
    logic       rd_ptr;
    logic [1:0] count;
    logic       push;
    logic       pop;

    // Full refuses the writer, so no byte is ever overwritten.
    assign in_s.ready  = (count != BUF_FULL);
    assign out_s.valid = (count != BUF_EMPTY);
    assign out_s.data  = slot[rd_ptr];
    assign push        = in_s.valid & in_s.ready;
    assign pop         = out_s.valid & out_s.ready;

    // Each slot is a plain register written when the pointer selects it.
    for (genvar k = 0; k < 2; k++)
    begin : g_slot
        always_ff @(posedge i_clk)
        begin
            if (i_sys_rst)
                slot[k] <= REG_RESET;
            else if (push && wr_ptr == 1'(k))
                slot[k] <= in_s.data;
        end
    end

    // Pointers and fill level.
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= BUF_EMPTY;
        end
        else
        begin
            wr_ptr <= wr_ptr ^ push;
            rd_ptr <= rd_ptr ^ pop;
            count  <= count + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// File: src/uart_channel.sv
// One asynchronous serial channel with its host register set.
`timescale 1ns/100ps
module uart_channel
    import uart_chan_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_baud_tick,
    input  wire logic       i_mode_68,
    input  wire logic       i_cs,
    input  wire logic       i_rd,
    input  wire logic       i_wr,
    input  wire logic [2:0] i_addr,
    input  wire logic [7:0] i_data,
    output logic      [7:0] o_data,
    output logic            o_data_oe,
    input  wire logic       i_rx,
    output logic            o_tx,
    input  wire logic       i_cts_n,
    input  wire logic       i_dsr_n,
    input  wire logic       i_ri_n,
    input  wire logic       i_cd_n,
    output logic            o_dtr_n,
    output logic            o_rts_n,
    output logic            o_int,
    output logic            o_int_oe,
    output logic            o_irq_n,
    output logic            o_irq_n_oe
);
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;

    // Address decode shared by reads and writes.
    function automatic logic hit(input logic [2:0] addr, input logic [2:0] reg_addr);
        hit = (addr == reg_addr);
    endfunction

    logic [7:0] interrupt_mask;
    logic [7:0] line_format;
    logic [7:0] modem_outputs;
    logic [7:0] rx_holding;
    logic       rx_full;
    logic       overrun;
    logic       parity_err;
    logic       frame_err;
    logic       break_seen;
    logic       tx_int;
    logic       thr_empty_prev;
    logic [3:0] modem_prev;
    logic       modem_delta;
    logic       loop;
    logic       rd_data;
    logic       rd_cause;
    logic       rd_line;
    logic       wr_data;
    logic [3:0] cause;
    logic       thr_empty;
    logic       tx_idle_all;
    logic [3:0] modem_now;

    byte_stream_if tx_in ();
    byte_stream_if tx_out ();

    ////////////////////////////////////////////////////////////////////////////
    // Host access strobes.

    assign loop     = modem_outputs[MDM_LOOP];
    assign rd_data  = i_cs & i_rd & hit(i_addr, ADDR_DATA);
    assign rd_cause = i_cs & i_rd & hit(i_addr, ADDR_CAUSE);
    assign rd_line  = i_cs & i_rd & hit(i_addr, ADDR_LINE);
    assign wr_data  = i_cs & i_wr & hit(i_addr, ADDR_DATA);

    // Control registers; unused upper bits are never stored so they read zero.
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            interrupt_mask <= REG_RESET;
            line_format    <= REG_RESET;
            modem_outputs  <= REG_RESET;
        end
        else if (i_cs && i_wr)
        begin
            if (hit(i_addr, ADDR_MASK))
                interrupt_mask <= i_data & MASK_WMASK;
            if (hit(i_addr, ADDR_FMT))
                line_format <= i_data & FMT_WMASK;
            if (hit(i_addr, ADDR_MODEM))
                modem_outputs <= i_data & MODEM_WMASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit path: the buffer is the holding stage, refused writes are lost.

    assign tx_in.data  = i_data;
    assign tx_in.valid = wr_data;

    byte_pair_buffer u_tx_buf (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .in_s      (tx_in.snk),
        .out_s     (tx_out.src)
    );

    tx_state_t  tx_state;
    logic [4:0] tx_cnt;
    logic [2:0] tx_bits;
    logic [7:0] tx_shreg;
    logic       tx_par;
    logic       tx_bit;
    logic       tx_line;
    logic [4:0] stop_end;

    assign thr_empty    = ~tx_out.valid;
    assign tx_idle_all  = thr_empty & (tx_state == TX_IDLE);
    assign tx_out.ready = (tx_state == TX_IDLE);
    // One and a half stop bits only apply to five-bit characters.
    assign stop_end = !line_format[FMT_STOP] ? STOP_ONE :
                      (line_format[1:0] == LEN_FIVE) ? STOP_HALF3 : STOP_TWO;

    // Transmit shifter; a new byte is taken at once, bit timing follows the tick.
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            tx_state <= TX_IDLE;
            tx_cnt   <= 5'h00;
            tx_bits  <= 3'h0;
            tx_shreg <= REG_RESET;
            tx_par   <= 1'b0;
        end
        else if (tx_state == TX_IDLE)
        begin
            if (tx_out.valid)
            begin
                tx_shreg <= tx_out.data;
                tx_par   <= parity_bit(tx_out.data, line_format);
                tx_state <= TX_START;
                tx_cnt   <= 5'h00;
            end
        end
        else if (i_baud_tick)
        begin
            tx_cnt <= tx_cnt + 5'h01;
            case (tx_state)
                TX_START:
                    if (tx_cnt[3:0] == BIT_LAST)
                    begin
                        tx_state <= TX_DATA;
                        tx_cnt   <= 5'h00;
                        tx_bits  <= 3'h0;
                    end
                TX_DATA:
                    if (tx_cnt[3:0] == BIT_LAST)
                    begin
                        tx_shreg <= tx_shreg >> 1;
                        tx_bits  <= tx_bits + 3'h1;
                        tx_cnt   <= 5'h00;
                        if (tx_bits == {1'b1, line_format[1:0]})
                            tx_state <= line_format[FMT_PAR_EN] ? TX_PAR : TX_STOP;
                    end
                TX_PAR:
                    if (tx_cnt[3:0] == BIT_LAST)
                    begin
                        tx_state <= TX_STOP;
                        tx_cnt   <= 5'h00;
                    end
                TX_STOP:
                    if (tx_cnt == stop_end)
                        tx_state <= TX_IDLE;
                default:
                    tx_state <= TX_IDLE;
            endcase
        end
    end

    // Serial level of the current bit, least significant data bit first.
    always_comb
    begin
        case (tx_state)
            TX_START: tx_bit = 1'b0;
            TX_DATA:  tx_bit = tx_shreg[0];
            TX_PAR:   tx_bit = tx_par;
            default:  tx_bit = 1'b1;
        endcase
    end

    assign tx_line = line_format[FMT_BREAK] ? 1'b0 : tx_bit;

    ////////////////////////////////////////////////////////////////////////////
    // Receive path.

    rx_state_t  rx_state;
    logic       rx_line;
    logic       rx_prev;
    logic [3:0] rx_cnt;
    logic [2:0] rx_bits;
    logic [7:0] rx_shreg;
    logic       rx_par;
    logic [7:0] rx_word;
    logic       rx_done;
    logic       rx_ferr;
    logic       rx_perr;
    logic       rx_brk;
    logic       rx_free;
    logic [7:0] rx_aligned;

    // In loop-back the receiver hears the transmitter instead of the pin.
    assign rx_line    = loop ? tx_line : i_rx;
    assign rx_aligned = rx_shreg >> (2'h3 - line_format[1:0]);

    // Receive sequencer, advanced only on 16x ticks.
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            rx_state <= RX_IDLE;
            rx_prev  <= 1'b1;
            rx_cnt   <= 4'h0;
            rx_bits  <= 3'h0;
            rx_shreg <= REG_RESET;
            rx_par   <= 1'b0;
            rx_done  <= 1'b0;
            rx_word  <= REG_RESET;
            rx_ferr  <= 1'b0;
            rx_perr  <= 1'b0;
            rx_brk   <= 1'b0;
        end
        else
        begin
            rx_done <= 1'b0;
            if (i_baud_tick)
            begin
                rx_prev <= rx_line;
                rx_cnt  <= rx_cnt + 4'h1;
                case (rx_state)
                    RX_IDLE:
                        if (rx_prev && !rx_line)
                        begin
                            rx_state <= RX_START;
                            rx_cnt   <= 4'h0;
                        end
                    RX_START:
                        if (rx_cnt == START_CHECK)
                        begin
                            // A glitch shorter than half a bit is dropped here.
                            rx_state <= rx_line ? RX_IDLE : RX_DATA;
                            rx_cnt   <= 4'h0;
                            rx_bits  <= 3'h0;
                        end
                    RX_DATA:
                        if (rx_cnt == BIT_LAST)
                        begin
                            rx_shreg <= {rx_line, rx_shreg[7:1]};
                            rx_bits  <= rx_bits + 3'h1;
                            if (rx_bits == {1'b1, line_format[1:0]})
                                rx_state <= line_format[FMT_PAR_EN] ? RX_PAR : RX_STOP;
                        end
                    RX_PAR:
                        if (rx_cnt == BIT_LAST)
                        begin
                            rx_par   <= rx_line;
                            rx_state <= RX_STOP;
                        end
                    RX_STOP:
                        if (rx_cnt == BIT_LAST)
                        begin
                            rx_state <= RX_IDLE;
                            rx_done  <= 1'b1;
                            rx_word  <= rx_aligned;
                            rx_ferr  <= ~rx_line;
                            rx_perr  <= line_format[FMT_PAR_EN] &&
                                        (rx_par != parity_bit(rx_aligned, line_format));
                            rx_brk   <= (rx_aligned == REG_RESET) && !rx_line &&
                                        !(line_format[FMT_PAR_EN] && rx_par);
                        end
                    default:
                        rx_state <= RX_IDLE;
                endcase
            end
        end
    end

    // A read in the same cycle frees the holding register for the new byte.
    assign rx_free = ~rx_full | rd_data;

    // Receive holding register; an overrun never disturbs the held byte.
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            rx_holding <= REG_RESET;
            rx_full    <= 1'b0;
        end
        else if (rx_done && rx_free)
        begin
            rx_holding <= rx_word;
            rx_full    <= 1'b1;
        end
        else if (rd_data)
            rx_full <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt sources and priority.

    logic clr_line;
    logic clr_tx;
    logic clr_modem;
    logic set_tx;

    assign clr_line  = rd_line | (rd_cause && cause == CAUSE_LINE);
    assign clr_tx    = (tx_in.valid & tx_in.ready) | (rd_cause && cause == CAUSE_TX);
    assign clr_modem = rd_cause && cause == CAUSE_MODEM;
    assign set_tx    = thr_empty & ~thr_empty_prev;

    // Sticky error flags; a new event wins over a clear in the same cycle.
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            overrun    <= 1'b0;
            parity_err <= 1'b0;
            frame_err  <= 1'b0;
            break_seen <= 1'b0;
        end
        else
        begin
            overrun    <= (rx_done & ~rx_free) | (overrun & ~clr_line);
            parity_err <= (rx_done & rx_perr) | (parity_err & ~clr_line);
            frame_err  <= (rx_done & rx_ferr) | (frame_err & ~clr_line);
            break_seen <= (rx_done & rx_brk) | (break_seen & ~clr_line);
        end
    end

    // Modem inputs, replaced by the control bits in loop-back.
    assign modem_now = loop ? ~{modem_outputs[MDM_OUT2], modem_outputs[MDM_OUT1],
                                modem_outputs[MDM_DTR], modem_outputs[MDM_RTS]}
                            : {i_cd_n, i_ri_n, i_dsr_n, i_cts_n};

    // Transmit-empty and modem-change flags.
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            tx_int         <= 1'b1;
            thr_empty_prev <= 1'b1;
            modem_prev     <= 4'hF;
            modem_delta    <= 1'b0;
        end
        else
        begin
            thr_empty_prev <= thr_empty;
            modem_prev     <= modem_now;
            tx_int         <= set_tx | (tx_int & ~clr_tx);
            modem_delta    <= (modem_now != modem_prev) | (modem_delta & ~clr_modem);
        end
    end

    // Priority encoder; only enabled sources take part.
    always_comb
    begin
        if (interrupt_mask[MASK_LINE] && (overrun | parity_err | frame_err | break_seen))
            cause = CAUSE_LINE;
        else if (interrupt_mask[MASK_RX] && rx_full)
            cause = CAUSE_RX;
        else if (interrupt_mask[MASK_TX] && tx_int)
            cause = CAUSE_TX;
        else if (interrupt_mask[MASK_MODEM] && modem_delta)
            cause = CAUSE_MODEM;
        else
            cause = CAUSE_NONE;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data, pins and interrupt outputs from flip-flops, except o_irq_n, which is tied low.

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            o_data     <= REG_RESET;
            o_data_oe  <= 1'b0;
            o_tx       <= 1'b1;
            o_dtr_n    <= 1'b1;
            o_rts_n    <= 1'b1;
            o_int      <= 1'b0;
            o_int_oe   <= 1'b0;
            o_irq_n_oe <= 1'b0;
        end
        else
        begin
            o_data_oe <= i_cs & i_rd;
            if (i_cs && i_rd)
            begin
                case (i_addr)
                    ADDR_DATA:  o_data <= rx_holding;
                    ADDR_MASK:  o_data <= interrupt_mask;
                    ADDR_CAUSE: o_data <= {4'h0, cause};
                    ADDR_FMT:   o_data <= line_format;
                    ADDR_MODEM: o_data <= modem_outputs;
                    ADDR_LINE:  o_data <= {1'b0, tx_idle_all, thr_empty, break_seen,
                                           frame_err, parity_err, overrun, rx_full};
                    default:    o_data <= REG_RESET;
                endcase
            end
            // The pins idle high while looped back.
            o_tx       <= loop | tx_line;
            o_dtr_n    <= loop | ~modem_outputs[MDM_DTR];
            o_rts_n    <= loop | ~modem_outputs[MDM_RTS];
            o_int      <= (cause != CAUSE_NONE);
            o_int_oe   <= ~i_mode_68 & modem_outputs[MDM_OUT2];
            o_irq_n_oe <= i_mode_68 & (cause != CAUSE_NONE);
        end
    end

    // The wired-OR request only ever pulls low.
    assign o_irq_n = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    thr_load_a: assert property ((wr_data && tx_in.ready) |=> !thr_empty)
        else $error("accepted byte did not reach the holding stage");
    thr_flag_a: assert property ((rd_line && thr_empty) |=> o_data[5])
        else $error("holding-empty flag not reported");
    start_drop_a: assert property ((i_baud_tick && rx_state == RX_START &&
        rx_cnt == START_CHECK && rx_line) |=> rx_state == RX_IDLE)
        else $error("false start was accepted");
    line_gate_a: assert property (!interrupt_mask[MASK_LINE] |-> cause != CAUSE_LINE)
        else $error("masked line status raised an interrupt");
    rx_cause_a: assert property ((interrupt_mask[MASK_RX] && rx_full &&
        !interrupt_mask[MASK_LINE]) |-> cause == CAUSE_RX)
        else $error("receive-ready interrupt missing");
    cause_clear_a: assert property ((rd_cause && cause == CAUSE_TX && !set_tx)
        |=> !tx_int)
        else $error("reported transmit cause not cleared");
    break_hold_a: assert property ((line_format[FMT_BREAK] && !loop) |=> !o_tx)
        else $error("break not driven on the line");
    pin_invert_a: assert property (##1 o_dtr_n == ($past(loop) |
        !$past(modem_outputs[MDM_DTR])))
        else $error("terminal-ready pin wrong");
    int_drive_a: assert property ((!i_mode_68 && modem_outputs[MDM_OUT2]) |=> o_int_oe)
        else $error("interrupt pin not enabled");
    overrun_keep_a: assert property ((rx_done && !rx_free) |=>
        overrun && rx_holding == $past(rx_holding))
        else $error("overrun disturbed the held byte");
endmodule

// File: bench/far_serial_model.sv
// Far-end serial device: sends frames into the channel and captures its frames.
`timescale 1ns/100ps
module far_serial_model (
    input  wire logic i_clk,
    input  wire logic i_tick,
    input  wire logic i_line,
    output logic      o_line
);
    logic [10:0] got;
    initial o_line = 1'b1;
    ////////////////////////////////////////////////////////////////////////////////
    // Each bit stands t ticks, first bit first; the line returns to mark after.
    task automatic send(input logic [10:0] bits, input int n, input int t);
        for (int k = 0; k < n; k++)
        begin
            o_line <= bits[k];
            repeat (t) @(posedge i_clk iff i_tick);
        end
        o_line <= 1'b1;
    endtask
    // Sampling at bit centres keeps the capture clear of the output flop's edge.
    task automatic grab(input int n);
        got = '1;
        wait (i_line === 1'b0);
        repeat (8) @(posedge i_clk iff i_tick);
        for (int k = 0; k < n; k++)
        begin
            got[k] = i_line;
            repeat (16) @(posedge i_clk iff i_tick);
        end
    endtask
endmodule

// File: bench/tb_top.sv
// Self-checking bench for one serial channel with a queue-based model.
`timescale 1ns/100ps
module tb_top
    import uart_chan_pkg::*;
;
    logic i_clk = 0, i_sys_rst = 1, tick = 0, mode = 0, cs = 0, rd_s = 0, wr_s = 0, p;
    logic [2:0] addr = 0;
    logic [7:0] wd = 0, rdat, v, d;
    logic [7:0] fm [3] = '{8'h1B, 8'h28, 8'h0A};
    logic rx, tx, dtr_n, rts_n, int_oe, irq_oe, doe, intr, irqn;
    logic [10:0] e;
    logic [4:0] seen;
    int mismatches = 0, cmp_count = 0, seed = 32'h478ac16b, m;
    logic [7:0] q[$];
    uart_channel uart_channel_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_baud_tick(tick),
        .i_mode_68(mode), .i_cs(cs), .i_rd(rd_s), .i_wr(wr_s), .i_addr(addr), .i_data(wd),
        .o_data(rdat), .o_data_oe(doe), .i_rx(rx), .o_tx(tx), .i_cts_n(1'b1), .i_dsr_n(1'b1),
        .i_ri_n(1'b1), .i_cd_n(1'b1), .o_dtr_n(dtr_n), .o_rts_n(rts_n), .o_int(intr),
        .o_int_oe(int_oe), .o_irq_n(irqn), .o_irq_n_oe(irq_oe));
    far_serial_model far_serial_model_inst (.i_clk(i_clk), .i_tick(tick), .i_line(tx),
        .o_line(rx));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock and a 16x tick on every other cycle to keep frames short.
    always #12.5 i_clk = ~i_clk;
    always @(negedge i_clk) tick <= ~tick;
    // Every comparison is counted; four-state compare so an unknown matches only an unknown.
    task automatic chk(input logic [10:0] s, input logic [10:0] x);
        cmp_count++;
        if (s !== x)
        begin
            mismatches++;
            $display("MISMATCH %0t got %h exp %h", $time, s, x);
        end
    endtask
    // One bus cycle; read data is taken once the registered answer has settled.
    task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] dd);
        @(negedge i_clk);
        cs = 1;
        wr_s = w;
        rd_s = ~w;
        addr = a;
        wd = dd;
        @(negedge i_clk);
        cs = 0;
        wr_s = 0;
        rd_s = 0;
        v = doe ? rdat : 8'hXX;
    endtask
    task automatic rchk(input logic [2:0] a, input logic [7:0] x);
        acc(0, a, 8'h00);
        chk(v, x);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // The whole sequence needs well under ten thousand cycles.
    initial
    begin
        repeat (40000) @(posedge i_clk);
        mismatches++;
        tally_and_finish();
    end
    initial
    begin
        repeat (4) @(negedge i_clk);
        i_sys_rst = 0;
        rchk(ADDR_CAUSE, 8'h01);
        rchk(ADDR_LINE, 8'h60);
        acc(1, ADDR_MASK, 8'hFF);
        rchk(ADDR_MASK, 8'h0F);
        rchk(ADDR_CAUSE, 8'h02);
        rchk(ADDR_CAUSE, 8'h01);
        acc(1, ADDR_MASK, 8'h01);
        acc(1, ADDR_MODEM, 8'hFF);
        rchk(ADDR_MODEM, 8'h1F);
        chk({dtr_n, rts_n, int_oe, intr}, 4'hE);
        acc(1, ADDR_MODEM, 8'h03);
        @(negedge i_clk);
        chk({dtr_n, rts_n, int_oe}, 3'h0);
        // The loop-back toggling above left a modem change pending.
        acc(1, ADDR_MASK, 8'h08);
        rchk(ADDR_CAUSE, 8'h00);
        rchk(ADDR_CAUSE, 8'h01);
        acc(1, ADDR_MASK, 8'h01);
        acc(1, ADDR_MODEM, 8'h10);
        // Loop-back frames in random formats; the model queue holds what must return.
        repeat (4)
        begin
            e = 11'($random(seed));
            d = 8'($random(seed));
            acc(1, ADDR_FMT, {2'h0, e[5:0]});
            q.push_back(d & (8'hFF >> (3 - e[1:0])));
            acc(1, ADDR_DATA, d);
            v = 0;
            seen = 5'h00;
            // Each poll clears the error bits, so every poll result is collected.
            for (int k = 0; k < 900 && (v & 8'h41) !== 8'h41; k++)
            begin
                acc(0, ADDR_LINE, 8'h00);
                seen = seen | v[4:0];
            end
            chk(seen, 5'h01);
            rchk(ADDR_CAUSE, 8'h04);
            rchk(ADDR_DATA, q.pop_front());
        end
        acc(1, ADDR_MODEM, 8'h00);
        // Frames on the wire: start, data first bit lowest, parity, stop.
        foreach (fm[i])
        begin
            d = 8'($random(seed));
            acc(1, ADDR_FMT, fm[i]);
            m = 5 + fm[i][1:0];
            e = 11'h7FE;
            p = ~fm[i][4];
            for (int k = 0; k < m; k++)
            begin
                e[k + 1] = d[k];
                p ^= d[k];
            end
            if (fm[i][5]) p = ~fm[i][4];
            if (fm[i][3]) e[m + 1] = p;
            fork
                far_serial_model_inst.grab(m + 2 + fm[i][3]);
                acc(1, ADDR_DATA, d);
            join
            chk(far_serial_model_inst.got, e);
        end
        acc(1, ADDR_FMT, 8'h43);
        @(negedge i_clk);
        chk(tx, 1'b0);
        acc(1, ADDR_FMT, 8'h03);
        far_serial_model_inst.send(11'h000, 1, 4);
        repeat (40) @(negedge i_clk);
        rchk(ADDR_LINE, 8'h60);
        d = 8'($random(seed));
        far_serial_model_inst.send({2'b11, d, 1'b0}, 10, 16);
        @(negedge i_clk);
        far_serial_model_inst.send({2'b11, ~d, 1'b0}, 10, 16);
        @(negedge i_clk);
        mode = 1;
        @(negedge i_clk);
        chk({irq_oe, int_oe, intr, irqn}, 4'hA);
        rchk(ADDR_LINE, 8'h63);
        rchk(ADDR_DATA, d);
        // An all-zero frame with a low stop bit raises break and framing errors.
        far_serial_model_inst.send(11'h000, 10, 16);
        acc(1, ADDR_MASK, 8'h05);
        rchk(ADDR_CAUSE, 8'h06);
        rchk(ADDR_CAUSE, 8'h04);
        rchk(ADDR_DATA, 8'h00);
        tally_and_finish();
    end
endmodule
